/* File: core/tpr_pkg.sv */
// Purpose: shared constants and state types of the thermopile readout link
// Assumes: 10 MHz system clock on both ends
// Notes: times are held in their own unit; cycle counts are derived in the modules
package tpr_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_STARTUP_IF_US = 1000;
  localparam int T_STARTUP_CONV_US = 2500;
  localparam int T_WAKE_IF_US = 500;
  localparam int T_WAKE_CONV_US = 2000;
  localparam int T_UPD16_US = 45000;
  localparam int T_UPD8_US = 20000;
  localparam int T_UPD4_US = 15000;
  localparam int T_UPD2_US = 10000;
  localparam int T_UPD1_US = 5000;
  localparam int T_SCL_PERIOD_NS = 10000;

  // ----------------------------------------------------------------
  // commands, addresses, status layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_AVG16 = 8'haf;
  localparam logic [7:0] CMD_AVG8 = 8'hae;
  localparam logic [7:0] CMD_AVG4 = 8'had;
  localparam logic [7:0] CMD_AVG2 = 8'hac;
  localparam logic [7:0] CMD_AVG1 = 8'haa;
  localparam logic [7:0] CMD_CAL_LAST = 8'h39;
  localparam logic [5:0] CAL_WORD_ADDR = 6'h02;
  localparam logic [6:0] DEF_TARGET_ADDR = 7'h00;
  localparam logic [6:0] ALT_TARGET_ADDR = 7'h1e;
  localparam int STAT_BUSY_BIT = 5;
  localparam int STAT_MEMERR_BIT = 2;
  localparam int ADC_W = 24;
  localparam int CAL_W = 16;
  localparam int CAL_AW = 6;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_ADDR = 3'b001, D_AACK = 3'b010, D_RX = 3'b011,
    D_WACK = 3'b100, D_TX = 3'b101, D_RACK = 3'b110, D_SKIP = 3'b111
  } tpr_bus_e;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_WAIT = 3'b001, M_REQ = 3'b010, M_ACC = 3'b011, M_HOLD = 3'b100
  } tpr_meas_e;

  typedef enum logic [3:0] {
    H_IDLE = 4'h0, H_START = 4'h1, H_LO_A = 4'h2, H_LO_B = 4'h3, H_HI_A = 4'h4,
    H_HI_B = 4'h5, H_STOP_A = 4'h6, H_STOP_B = 4'h7, H_STOP_C = 4'h8
  } tpr_host_e;

endpackage

/* File: core/tpr_if.sv */
// Purpose: two-wire link between controller and sensor
// Assumes: scl driven push-pull by the controller, sda open drain
// Notes: sda resolves low whenever an enabled driver outputs low
`timescale 1ns/1ps
interface tpr_if;
  logic scl;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda;

  assign sda = ((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o)) ? 1'b0 : 1'b1;

  modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (output scl, output sda_host_o, output sda_host_oe, input sda);
endinterface

/* File: core/tpr_device.sv */
// Purpose: sensor end: serial target, command decode, averaged readout
// Assumes: scl slow against clk; no clock stretching; adc and cal memory outside
// Notes: a command acts only when its message closes with stop
`timescale 1ns/1ps
module tpr_device import tpr_pkg::*; #(
  parameter int STA1_CYC = T_STARTUP_IF_US * 1000 / CLK_PERIOD_NS,
  parameter int STA2_CYC = T_STARTUP_CONV_US * 1000 / CLK_PERIOD_NS,
  parameter int WUP1_CYC = T_WAKE_IF_US * 1000 / CLK_PERIOD_NS,
  parameter int WUP2_CYC = T_WAKE_CONV_US * 1000 / CLK_PERIOD_NS,
  parameter int UPD16_CYC = T_UPD16_US * 1000 / CLK_PERIOD_NS,
  parameter int UPD8_CYC = T_UPD8_US * 1000 / CLK_PERIOD_NS,
  parameter int UPD4_CYC = T_UPD4_US * 1000 / CLK_PERIOD_NS,
  parameter int UPD2_CYC = T_UPD2_US * 1000 / CLK_PERIOD_NS,
  parameter int UPD1_CYC = T_UPD1_US * 1000 / CLK_PERIOD_NS,
  parameter bit ADDR_FROM_CAL = 1'b1,
  parameter logic [6:0] FIXED_ADDR = DEF_TARGET_ADDR
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial link
  tpr_if.dev bus,
  // power state
  input wire logic sleep_req,
  // calibration memory
  output logic [CAL_AW-1:0] cal_addr,
  input wire logic [CAL_W-1:0] cal_data,
  input wire logic mem_err,
  // adc
  output logic adc_req,
  input wire logic adc_valid,
  input wire logic [ADC_W-1:0] adc_obj,
  input wire logic [ADC_W-1:0] adc_sen,
  // status
  output logic busy
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {bus.scl, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {bus.sda, sda_s1, sda_s2};
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign bus_stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

  // ----------------------------------------------------------------
  // power-up, sleep and address capture
  // ----------------------------------------------------------------
  logic [31:0] if_wait, next_if_wait, conv_wait, next_conv_wait;
  logic asleep, next_asleep, addr_loaded, next_addr_loaded;
  logic [6:0] dev_addr, next_dev_addr;
  logic if_ready, conv_ready;
  tpr_bus_e st, next_st;
  tpr_meas_e m_st, next_m_st;

  always_comb begin
    next_if_wait = (if_wait != 32'h0) ? if_wait - 32'h1 : 32'h0;
    next_conv_wait = (conv_wait != 32'h0) ? conv_wait - 32'h1 : 32'h0;
    // sleep is only entered with the bus and the measurement idle
    next_asleep = asleep ? sleep_req : (sleep_req && st == D_IDLE && m_st == M_IDLE);
    if (asleep) begin
      next_if_wait = 32'(WUP1_CYC);
      next_conv_wait = 32'(WUP2_CYC);
    end
    next_addr_loaded = 1'b1;
    next_dev_addr = dev_addr;
    if (!addr_loaded) begin
      next_dev_addr = ADDR_FROM_CAL ? cal_data[6:0] : FIXED_ADDR;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      if_wait <= 32'(STA1_CYC);
      conv_wait <= 32'(STA2_CYC);
      asleep <= 1'b0;
      addr_loaded <= 1'b0;
      dev_addr <= FIXED_ADDR;
    end else begin
      if_wait <= next_if_wait;
      conv_wait <= next_conv_wait;
      asleep <= next_asleep;
      addr_loaded <= next_addr_loaded;
      dev_addr <= next_dev_addr;
    end
  end

  assign if_ready = (if_wait == 32'h0) && !asleep && addr_loaded;
  assign conv_ready = (conv_wait == 32'h0) && !asleep;

  // ----------------------------------------------------------------
  // serial target
  // ----------------------------------------------------------------
  logic [3:0] cnt, next_cnt;
  logic [7:0] rx_sh, next_rx_sh, cmd_pend, next_cmd_pend;
  logic rw, next_rw, cmd_v, next_cmd_v, sda_oe, next_sda_oe;
  logic [55:0] rd_sh, next_rd_sh;
  logic [7:0] stat;
  logic [47:0] out_data;
  logic cal_mode;
  logic [CAL_AW-1:0] cal_sel;
  logic [ADC_W-1:0] res_obj, res_sen;
  logic cmd_exec;

  always_comb begin
    stat = 8'h00;
    stat[STAT_BUSY_BIT] = busy;
    stat[STAT_MEMERR_BIT] = mem_err;
  end

  // cal word sits in the top two data bytes, the rest reads zero
  assign out_data = cal_mode ? {cal_data, 32'h0} : {res_obj, res_sen};

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_rx_sh = rx_sh;
    next_rw = rw;
    next_rd_sh = rd_sh;
    next_cmd_pend = cmd_pend;
    next_cmd_v = cmd_v;
    next_sda_oe = sda_oe;
    if (bus_start) begin
      next_st = D_ADDR;
      next_cnt = 4'h0;
      next_cmd_v = 1'b0;
      next_sda_oe = 1'b0;
    end else if (bus_stop) begin
      next_st = D_IDLE;
      next_cmd_v = 1'b0;
      next_sda_oe = 1'b0;
    end else begin
      case (st)
        D_ADDR, D_RX: begin
          if (scl_rise) begin
            next_rx_sh = {rx_sh[6:0], sda_s2};
            next_cnt = cnt + 4'h1;
          end
          if (scl_fall && cnt == 4'h8) begin
            if (st == D_RX) begin
              next_st = D_WACK;
              next_sda_oe = 1'b1;
              next_cmd_pend = rx_sh;
              next_cmd_v = 1'b1;
            end else if (rx_sh[7:1] == dev_addr && if_ready) begin
              next_st = D_AACK;
              next_rw = rx_sh[0];
              next_sda_oe = 1'b1;
            end else begin
              next_st = D_SKIP;
            end
          end
        end
        D_AACK: begin
          if (scl_fall) begin
            next_cnt = 4'h0;
            if (rw) begin
              next_st = D_TX;
              next_rd_sh = {stat, out_data};
              next_sda_oe = ~stat[7];
            end else begin
              next_st = D_RX;
              next_sda_oe = 1'b0;
            end
          end
        end
        D_WACK: begin
          if (scl_fall) begin
            next_st = D_RX;
            next_cnt = 4'h0;
            next_sda_oe = 1'b0;
          end
        end
        D_TX: begin
          if (scl_fall) begin
            next_rd_sh = {rd_sh[54:0], 1'b0};
            next_cnt = cnt + 4'h1;
            if (cnt == 4'h7) begin
              next_st = D_RACK;
              next_sda_oe = 1'b0;
            end else begin
              next_sda_oe = ~rd_sh[54];
            end
          end
        end
        D_RACK: begin
          if (scl_rise && sda_s2) begin
            next_st = D_SKIP;
          end else if (scl_fall) begin
            next_st = D_TX;
            next_cnt = 4'h0;
            next_sda_oe = ~rd_sh[55];
          end
        end
        default: begin
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= D_IDLE;
      cnt <= 4'h0;
      rx_sh <= 8'h00;
      rw <= 1'b0;
      rd_sh <= 56'h0;
      cmd_pend <= 8'h00;
      cmd_v <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      rx_sh <= next_rx_sh;
      rw <= next_rw;
      rd_sh <= next_rd_sh;
      cmd_pend <= next_cmd_pend;
      cmd_v <= next_cmd_v;
      sda_oe <= next_sda_oe;
    end
  end

  assign bus.sda_dev_o = 1'b0;
  assign bus.sda_dev_oe = sda_oe;
  assign cmd_exec = bus_stop && cmd_v;

  // ----------------------------------------------------------------
  // measurement and averaging
  // ----------------------------------------------------------------
  logic [4:0] n_tgt, next_n_tgt, samp, next_samp;
  logic [2:0] shamt, next_shamt;
  logic [31:0] upd_cnt, next_upd_cnt, upd_tgt, next_upd_tgt;
  logic [ADC_W+3:0] acc_obj, next_acc_obj, acc_sen, next_acc_sen;
  logic [ADC_W-1:0] next_res_obj, next_res_sen;
  logic next_cal_mode;
  logic [CAL_AW-1:0] next_cal_sel;
  logic go;
  logic [4:0] go_n;
  logic [2:0] go_sh;
  logic [31:0] go_upd;

  always_comb begin
    go = 1'b1;
    go_n = 5'd1;
    go_sh = 3'd0;
    go_upd = 32'(UPD1_CYC);
    case (cmd_pend)
      CMD_AVG16: begin go_n = 5'd16; go_sh = 3'd4; go_upd = 32'(UPD16_CYC); end
      CMD_AVG8: begin go_n = 5'd8; go_sh = 3'd3; go_upd = 32'(UPD8_CYC); end
      CMD_AVG4: begin go_n = 5'd4; go_sh = 3'd2; go_upd = 32'(UPD4_CYC); end
      CMD_AVG2: begin go_n = 5'd2; go_sh = 3'd1; go_upd = 32'(UPD2_CYC); end
      CMD_AVG1: begin go_n = 5'd1; go_sh = 3'd0; go_upd = 32'(UPD1_CYC); end
      default: go = 1'b0;
    endcase
  end

  always_comb begin
    next_m_st = m_st;
    next_n_tgt = n_tgt;
    next_shamt = shamt;
    next_samp = samp;
    next_upd_tgt = upd_tgt;
    next_upd_cnt = (m_st == M_IDLE) ? 32'h0 : upd_cnt + 32'h1;
    next_acc_obj = acc_obj;
    next_acc_sen = acc_sen;
    next_res_obj = res_obj;
    next_res_sen = res_sen;
    next_cal_mode = cal_mode;
    next_cal_sel = cal_sel;
    case (m_st)
      M_IDLE: begin
        // commands arriving during a measurement are dropped
        if (cmd_exec && cmd_pend <= CMD_CAL_LAST) begin
          next_cal_mode = 1'b1;
          next_cal_sel = cmd_pend[CAL_AW-1:0];
        end else if (cmd_exec && go) begin
          next_m_st = M_WAIT;
          next_cal_mode = 1'b0;
          next_n_tgt = go_n;
          next_shamt = go_sh;
          next_upd_tgt = go_upd;
          next_samp = 5'd0;
          next_acc_obj = '0;
          next_acc_sen = '0;
        end
      end
      M_WAIT: begin
        if (conv_ready) begin
          next_m_st = M_REQ;
        end
      end
      M_REQ: next_m_st = M_ACC;
      M_ACC: begin
        if (adc_valid) begin
          next_acc_obj = acc_obj + {4'h0, adc_obj};
          next_acc_sen = acc_sen + {4'h0, adc_sen};
          next_samp = samp + 5'd1;
          next_m_st = (samp + 5'd1 == n_tgt) ? M_HOLD : M_REQ;
        end
      end
      M_HOLD: begin
        if (upd_cnt >= upd_tgt) begin
          next_res_obj = ADC_W'(acc_obj >> shamt);
          next_res_sen = ADC_W'(acc_sen >> shamt);
          next_m_st = M_IDLE;
        end
      end
      default: next_m_st = M_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      m_st <= M_IDLE;
      n_tgt <= 5'd1;
      shamt <= 3'd0;
      samp <= 5'd0;
      upd_tgt <= 32'h0;
      upd_cnt <= 32'h0;
      acc_obj <= '0;
      acc_sen <= '0;
      res_obj <= '0;
      res_sen <= '0;
      cal_mode <= 1'b0;
      cal_sel <= '0;
    end else begin
      m_st <= next_m_st;
      n_tgt <= next_n_tgt;
      shamt <= next_shamt;
      samp <= next_samp;
      upd_tgt <= next_upd_tgt;
      upd_cnt <= next_upd_cnt;
      acc_obj <= next_acc_obj;
      acc_sen <= next_acc_sen;
      res_obj <= next_res_obj;
      res_sen <= next_res_sen;
      cal_mode <= next_cal_mode;
      cal_sel <= next_cal_sel;
    end
  end

  assign busy = (m_st != M_IDLE);
  assign adc_req = (m_st == M_REQ);
  assign cal_addr = addr_loaded ? cal_sel : CAL_WORD_ADDR;

endmodule

/* File: core/tpr_host.sv */
// Purpose: controller end: generates scl, sends commands, reads results
// Assumes: target never stretches scl
// Notes: one transaction per request, always closed with stop
`timescale 1ns/1ps
module tpr_host import tpr_pkg::*; #(
  parameter int QTR_CYC = T_SCL_PERIOD_NS / 4 / CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial link
  tpr_if.host bus,
  // request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [6:0] target_addr,
  input wire logic [7:0] cmd_byte,
  input wire logic [2:0] cmd_len,
  // answer
  output logic rd_valid,
  output logic [7:0] rd_byte,
  output logic done,
  output logic nack
);

  // ----------------------------------------------------------------
  // sda synchroniser
  // ----------------------------------------------------------------
  logic sda_s1, sda_s2;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {sda_s1, sda_s2} <= 2'h3;
    end else begin
      {sda_s1, sda_s2} <= {bus.sda, sda_s1};
    end
  end

  // ----------------------------------------------------------------
  // bit and byte sequencer
  // ----------------------------------------------------------------
  tpr_host_e st, next_st;
  logic [15:0] tcnt, next_tcnt;
  logic scl, next_scl, oe, next_oe, rd, next_rd, ack_hi, next_ack_hi;
  logic [7:0] sh, next_sh, cbyte, next_cbyte, next_rd_byte;
  logic [3:0] bit_i, next_bit_i, byte_i, next_byte_i, last_i, next_last_i;
  logic next_rd_valid, next_done, next_nack, tick, is_rx, is_last;

  assign tick = (tcnt == 16'(QTR_CYC - 1));
  assign is_rx = rd && (byte_i != 4'h0);
  assign is_last = (byte_i == last_i);

  always_comb begin
    next_st = st;
    next_tcnt = (st == H_IDLE || tick) ? 16'h0 : tcnt + 16'h1;
    next_scl = scl;
    next_oe = oe;
    next_rd = rd;
    next_ack_hi = ack_hi;
    next_sh = sh;
    next_cbyte = cbyte;
    next_bit_i = bit_i;
    next_byte_i = byte_i;
    next_last_i = last_i;
    next_rd_byte = rd_byte;
    next_rd_valid = 1'b0;
    next_done = 1'b0;
    next_nack = nack;
    case (st)
      H_IDLE: begin
        if (cmd_valid) begin
          next_st = H_START;
          next_oe = 1'b1;
          next_rd = cmd_read;
          next_sh = {target_addr, cmd_read};
          next_cbyte = cmd_byte;
          next_last_i = cmd_read ? {1'b0, cmd_len} : 4'h1;
          next_bit_i = 4'h0;
          next_byte_i = 4'h0;
          next_nack = 1'b0;
        end
      end
      H_START: if (tick) begin next_scl = 1'b0; next_st = H_LO_A; end
      H_LO_A: begin
        if (tick) begin
          if (bit_i != 4'h8) begin
            next_oe = is_rx ? 1'b0 : ~sh[7];
          end else begin
            next_oe = is_rx && !is_last;
          end
          next_st = H_LO_B;
        end
      end
      H_LO_B: if (tick) begin next_scl = 1'b1; next_st = H_HI_A; end
      H_HI_A: begin
        if (tick) begin
          if (bit_i != 4'h8) begin
            next_sh = {sh[6:0], sda_s2};
            if (bit_i == 4'h7 && is_rx) begin
              next_rd_byte = {sh[6:0], sda_s2};
              next_rd_valid = 1'b1;
            end
          end else begin
            next_ack_hi = !is_rx && sda_s2;
          end
          next_st = H_HI_B;
        end
      end
      H_HI_B: begin
        if (tick) begin
          next_scl = 1'b0;
          next_st = H_LO_A;
          if (bit_i != 4'h8) begin
            next_bit_i = bit_i + 4'h1;
          end else if (ack_hi || is_last) begin
            next_nack = ack_hi;
            next_st = H_STOP_A;
          end else begin
            next_bit_i = 4'h0;
            next_byte_i = byte_i + 4'h1;
            next_sh = rd ? 8'h00 : cbyte;
          end
        end
      end
      H_STOP_A: if (tick) begin next_oe = 1'b1; next_st = H_STOP_B; end
      H_STOP_B: if (tick) begin next_scl = 1'b1; next_st = H_STOP_C; end
      H_STOP_C: begin
        if (tick) begin
          next_oe = 1'b0;
          next_done = 1'b1;
          next_st = H_IDLE;
        end
      end
      default: next_st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= H_IDLE;
      tcnt <= 16'h0;
      scl <= 1'b1;
      oe <= 1'b0;
      rd <= 1'b0;
      ack_hi <= 1'b0;
      sh <= 8'h00;
      cbyte <= 8'h00;
      bit_i <= 4'h0;
      byte_i <= 4'h0;
      last_i <= 4'h0;
      rd_byte <= 8'h00;
      rd_valid <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
    end else begin
      st <= next_st;
      tcnt <= next_tcnt;
      scl <= next_scl;
      oe <= next_oe;
      rd <= next_rd;
      ack_hi <= next_ack_hi;
      sh <= next_sh;
      cbyte <= next_cbyte;
      bit_i <= next_bit_i;
      byte_i <= next_byte_i;
      last_i <= next_last_i;
      rd_byte <= next_rd_byte;
      rd_valid <= next_rd_valid;
      done <= next_done;
      nack <= next_nack;
    end
  end

  // waiting for results and polling busy is left to the user side
  assign cmd_ready = (st == H_IDLE);
  assign bus.scl = scl;
  assign bus.sda_host_o = 1'b0;
  assign bus.sda_host_oe = oe;

endmodule

/* File: tb/tpr_link_asserts.sv */
// Purpose: checker on the link wires and measurement strobes
// Assumes: one clock domain, reset active high
// Notes: startup counter saturates once the conversion wait is over
`timescale 1ns/1ps
module tpr_link_asserts #(
  parameter int STA1_CYC = 400,
  parameter int STA2_CYC = 600
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_oe,
  // measurement
  input wire logic busy,
  input wire logic adc_req
);
  int up;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) up <= 0;
    else if (up < STA2_CYC) up <= up + 1;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);
  // sda rose three samples back and scl is still high: the stop that fires a command
  sequence s_after_stop;
    scl && $past(sda, 3) && !$past(sda, 4);
  endsequence
  sequence s_pulse;
    adc_req ##1 !adc_req;
  endsequence
  oe_scl_low_a: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device sda changed while scl high");
  quiet_start_a: assert property (up < STA1_CYC |-> !sda_dev_oe)
    else $error("device answered before startup time");
  conv_start_a: assert property (up < STA2_CYC |-> !adc_req)
    else $error("conversion before startup time");
  busy_stop_a: assert property ($rose(busy) |-> s_after_stop)
    else $error("busy rose without a preceding stop");
  adc_busy_a: assert property (adc_req |-> busy)
    else $error("sample request while not busy");
  adc_pulse_a: assert property (adc_req |-> s_pulse)
    else $error("sample request longer than one cycle");
  busy_hold_a: assert property ($rose(busy) |=> busy[*8])
    else $error("busy dropped too early");
  busy_fall_a: assert property ($fell(busy) |-> !adc_req)
    else $error("busy fell with sampling pending");
endmodule

/* File: tb/test_thermopile_i2c_command_readout.sv */
// Purpose: both link ends joined, driven from the controller request side
// Assumes: shortened startup, wake and update counts
// Notes: adc samples ramp so that averaging shows in the result
`timescale 1ns/1ps
module test_thermopile_i2c_command_readout import tpr_pkg::*;;
  logic clk, sys_rst, sleep_req, mem_err, adc_valid;
  logic cmd_valid, cmd_read;
  logic [6:0] target_addr;
  logic [7:0] cmd_byte;
  logic [2:0] cmd_len;
  logic [ADC_W-1:0] adc_obj, adc_sen;
  logic [CAL_AW-1:0] cal_addr;
  logic [CAL_W-1:0] cal_data;
  logic cmd_ready, rd_valid, done, nack, adc_req, busy;
  logic [7:0] rd_byte, q[$];
  int bad_count = 0, comparisons = 0, k = 0;
  always #50 clk = ~clk;
  // word 2 reads zero so the device takes address 0x00
  assign cal_data = cal_addr == CAL_WORD_ADDR ? 16'h0000 : {10'h2a5, cal_addr};
  always @(posedge clk) begin
    if (sys_rst) begin
      adc_valid <= 1'b0;
      adc_obj <= 24'h000000;
      adc_sen <= 24'h000000;
    end else begin
      adc_valid <= adc_req;
      if (adc_req) begin
        adc_obj <= 24'h400000 + 24'(2 * k);
        adc_sen <= 24'h800000 - 24'(2 * k);
        k <= k + 1;
      end
    end
  end
  tpr_if link();
  tpr_device #(.STA1_CYC(400), .STA2_CYC(600), .WUP1_CYC(400), .WUP2_CYC(500), .UPD16_CYC(1600),
    .UPD8_CYC(1200), .UPD4_CYC(800), .UPD2_CYC(600), .UPD1_CYC(400)) tpr_device_i (.clk(clk),
    .sys_rst(sys_rst), .bus(link), .sleep_req(sleep_req), .cal_addr(cal_addr), .cal_data(cal_data),
    .mem_err(mem_err), .adc_req(adc_req), .adc_valid(adc_valid), .adc_obj(adc_obj), .adc_sen(adc_sen),
    .busy(busy));
  tpr_host #(.QTR_CYC(8)) tpr_host_i (.clk(clk), .sys_rst(sys_rst), .bus(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .target_addr(target_addr), .cmd_byte(cmd_byte),
    .cmd_len(cmd_len), .rd_valid(rd_valid), .rd_byte(rd_byte), .done(done), .nack(nack));
  tpr_link_asserts #(.STA1_CYC(400), .STA2_CYC(600)) tpr_link_asserts_i (.clk(clk), .sys_rst(sys_rst),
    .scl(link.scl), .sda(link.sda), .sda_dev_oe(link.sda_dev_oe), .busy(busy), .adc_req(adc_req));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic rd, input logic [7:0] cb, input logic [2:0] n);
    int t;
    q.delete();
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_byte <= cb;
    cmd_len <= n;
    do @(negedge clk); while (cmd_ready !== 1'b1);
    @(posedge clk);
    cmd_valid <= 1'b0;
    for (t = 0; t < 20000 && done !== 1'b1; t++) begin
      @(negedge clk);
      if (rd_valid === 1'b1) q.push_back(rd_byte);
    end
    chk("done", 8'h01, {7'h00, done});
    // end on a rising edge so the caller's next drive lands there
    @(posedge clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_start();
    xfer(1'b0, 8'h05, 3'h0);
    chk("nack early", 8'h01, {7'h00, nack});
    repeat (200) @(posedge clk);
    target_addr <= ALT_TARGET_ADDR;
    xfer(1'b0, 8'h05, 3'h0);
    chk("nack other addr", 8'h01, {7'h00, nack});
    target_addr <= DEF_TARGET_ADDR;
    xfer(1'b0, 8'h05, 3'h0);
    chk("nack own addr", 8'h00, {7'h00, nack});
  endtask
  task automatic t_cal();
    logic [7:0] c[2] = '{8'h01, CMD_CAL_LAST};
    foreach (c[i]) begin
      xfer(1'b0, c[i], 3'h0);
      xfer(1'b1, 8'h00, 3'h3);
      chk("cal status", 8'h00, q[0]);
      chk("cal hi", {2'h2, 6'h29}, q[1]);
      chk("cal lo", {2'h1, c[i][5:0]}, q[2]);
    end
  endtask
  task automatic t_meas();
    logic [7:0] c[5] = '{CMD_AVG1, CMD_AVG2, CMD_AVG4, CMD_AVG8, CMD_AVG16};
    logic [47:0] e;
    foreach (c[i]) begin
      // samples run on from the ramp position left by earlier commands
      e = {24'h400000 + 24'(2 * k + (1 << i) - 1), 24'h800000 - 24'(2 * k + (1 << i) - 1)};
      xfer(1'b0, c[i], 3'h0);
      xfer(1'b1, 8'h00, 3'h1);
      chk("status busy", 8'h20, q[0]);
      for (int t = 0; t < 3000 && busy !== 1'b0; t++) @(negedge clk);
      xfer(1'b1, 8'h00, 3'h7);
      chk("status idle", 8'h00, q[0]);
      for (int b = 0; b < 6; b++) chk("result", e[47 - 8 * b -: 8], q[b + 1]);
    end
  endtask
  task automatic t_err();
    mem_err <= 1'b1;
    xfer(1'b1, 8'h00, 3'h1);
    chk("status memerr", 8'h04, q[0]);
    mem_err <= 1'b0;
    // an undefined command must not start a measurement
    xfer(1'b0, 8'hab, 3'h0);
    xfer(1'b1, 8'h00, 3'h1);
    chk("status unknown cmd", 8'h00, q[0]);
  endtask
  task automatic t_sleep();
    sleep_req <= 1'b1;
    repeat (20) @(posedge clk);
    xfer(1'b0, 8'h05, 3'h0);
    chk("nack asleep", 8'h01, {7'h00, nack});
    sleep_req <= 1'b0;
    xfer(1'b0, 8'h05, 3'h0);
    chk("nack waking", 8'h01, {7'h00, nack});
    repeat (500) @(posedge clk);
    xfer(1'b0, 8'h05, 3'h0);
    chk("nack awake", 8'h00, {7'h00, nack});
  endtask
  task automatic complete_run();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial clk = 1'b0;
  initial begin
    sys_rst <= 1'b1;
    sleep_req <= 1'b0;
    mem_err <= 1'b0;
    cmd_valid <= 1'b0;
    cmd_read <= 1'b0;
    target_addr <= DEF_TARGET_ADDR;
    cmd_byte <= 8'h00;
    cmd_len <= 3'h0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_start();
    t_cal();
    t_meas();
    t_err();
    t_sleep();
    complete_run();
  end
  // cut a hang well beyond the expected run length
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule
